/* rtl/clk_cfg_pkg.sv */
package clk_cfg_pkg;

   // Register offsets on the control port
   localparam logic [7:0] OFS_DIV_EN   = 8'h45;
   localparam logic [7:0] OFS_OUT_SRC  = 8'h46;
   localparam logic [7:0] OFS_OUT_DIV  = 8'h47;
   localparam logic [7:0] OFS_BOOST    = 8'h48;
   localparam logic [7:0] OFS_SAR      = 8'h49;

   // Values after reset
   localparam logic [7:0] RST_DIV_EN   = 8'h00;
   localparam logic [7:0] RST_OUT_SRC  = 8'h00;
   localparam logic [7:0] RST_OUT_DIV  = 8'h01;
   localparam logic [7:0] RST_BOOST    = 8'h00;
   localparam logic [7:0] RST_SAR      = 8'h00;

   // Writable bits; the rest are reserved and read as zero
   localparam logic [7:0] WMASK_DIV_EN  = 8'h4F;
   localparam logic [7:0] WMASK_OUT_SRC = 8'h07;
   localparam logic [7:0] WMASK_OUT_DIV = 8'hFF;
   localparam logic [7:0] WMASK_BOOST   = 8'h7F;
   localparam logic [7:0] WMASK_SAR     = 8'hFF;

   // Field positions, divider-enable register
   localparam int unsigned POS_MOD_ON   = 6;
   localparam int unsigned POS_PBCLK_ON = 3;
   localparam int unsigned POS_SBCLK_ON = 2;
   localparam int unsigned POS_PFS_ON   = 1;
   localparam int unsigned POS_SFS_ON   = 0;

   // Field positions, output clock divider register
   localparam int unsigned POS_OUT_ON   = 7;

   // Field positions, boost and SAR setup registers
   localparam int unsigned POS_SRC_AUTO_OFF = 5;
   localparam int unsigned POS_SRC_PICK     = 4;
   localparam int unsigned POS_EN_AUTO_OFF  = 3;
   localparam int unsigned POS_MAN_ON       = 2;
   localparam int unsigned POS_BOOST_MODE   = 6;

   // Output clock source codes; 6 and 7 are reserved
   localparam int unsigned  NUM_SRC      = 6;
   localparam logic [2:0]   SRC_PLL      = 3'h0;
   localparam logic [2:0]   SRC_PBCLK    = 3'h1;
   localparam logic [2:0]   SRC_SBCLK    = 3'h2;
   localparam logic [2:0]   SRC_CONTROL_PORT_CLOCK     = 3'h3;
   localparam logic [2:0]   SRC_OSC      = 3'h4;
   localparam logic [2:0]   SRC_DSP      = 3'h5;

   // Output divider ratio for code 0
   localparam logic [7:0]   OUT_RATIO_ZERO = 8'h80;

   // Source edges per half period of the ~12 MHz base rate
   localparam logic [5:0]   BASE_HALF_DEFAULT = 6'h01;

   typedef struct packed {
      logic [7:0] div_en;
      logic [7:0] out_src;
      logic [7:0] out_div;
      logic [7:0] boost;
      logic [7:0] sar;
   } reg_file_t;

   typedef struct packed {
      logic [11:0] cnt;
      logic        on;
      logic        level;
   } gen_state_t;

   typedef struct packed {
      logic [6:0] cnt;
      logic [7:0] ratio;
      logic [2:0] src;
      logic       on;
      logic       level;
   } out_state_t;

endpackage : clk_cfg_pkg

/* rtl/audio_adc_clock_divider_config.sv */
`timescale 1ns/10ps
`default_nettype none

module audio_adc_clock_divider_config
   import clk_cfg_pkg::*;
#(
   parameter logic [5:0] BASE_HALF = BASE_HALF_DEFAULT
) (
   input  wire logic                 sys_clk_i,
   input  wire logic                 reset_i,
   input  wire logic [7:0]           reg_addr_i,
   input  wire logic                 reg_wr_i,
   input  wire logic [7:0]           reg_wdata_i,
   input  wire logic                 reg_rd_i,
   output var  logic [7:0]           reg_rdata_o,
   input  wire logic [NUM_SRC-1:0]   source_clocks_i,
   input  wire logic                 boost_auto_osc_i,
   input  wire logic                 boost_auto_on_i,
   input  wire logic                 sar_auto_osc_i,
   input  wire logic                 sar_auto_on_i,
   output var  logic                 modulator_divider_on_o,
   output var  logic                 primary_bitclk_divider_on_o,
   output var  logic                 secondary_bitclk_divider_on_o,
   output var  logic                 primary_framesync_divider_on_o,
   output var  logic                 secondary_framesync_divider_on_o,
   output var  logic                 general_clock_output_o,
   output var  logic                 boost_clock_o,
   output var  logic                 sar_clock_o
);

   typedef struct packed {
      reg_file_t          regs;
      logic [7:0]         rdata;
      logic [NUM_SRC-1:0] sync1;
      logic [NUM_SRC-1:0] sync2;
      logic [NUM_SRC-1:0] prev;
      out_state_t         outd;
      gen_state_t         boost;
      gen_state_t         sar;
      logic               out_clk;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Half period in source edges for a power-of-two slow-down
   function automatic logic [11:0] half_count(input logic [2:0] shift);
      logic [11:0] base;
      base = {6'h00, BASE_HALF};
      half_count = base << shift;
   endfunction : half_count

   // Masked register write keeps reserved bits at zero
   function automatic logic [7:0] masked(input logic [7:0] data,
                                         input logic [7:0] mask);
      masked = data & mask;
   endfunction : masked

   // Step of a boost or SAR style generator
   function automatic gen_state_t gen_step(input gen_state_t cur,
                                           input logic       tick,
                                           input logic       on_now,
                                           input logic [2:0] shift);
      gen_state_t nxt;
      nxt = cur;
      if (tick) begin
         if (cur.cnt == 12'h000) begin
            // Only act on half-period boundaries so no runt appears
            nxt.cnt = half_count(shift) - 12'h001;
            nxt.on  = on_now;
            if (on_now) begin
               nxt.level = ~cur.level;
            end else begin
               nxt.level = 1'b0;
            end
         end else begin
            nxt.cnt = cur.cnt - 12'h001;
         end
      end
      gen_step = nxt;
   endfunction : gen_step

   logic [NUM_SRC-1:0] edge_seen;
   logic [NUM_SRC-1:0] level_now;
   logic               out_tick;
   logic               out_src_level;
   logic [7:0]         new_ratio;
   logic [2:0]         new_src;
   logic               new_on;
   logic [7:0]         half_ratio;
   logic               boost_osc;
   logic               boost_on;
   logic [2:0]         boost_shift;
   logic               sar_osc;
   logic               sar_on;
   logic [2:0]         sar_shift;

   always_comb begin
      s_d = s_q;

      // Two-stage synchronisers; edge detection reads the second stage
      s_d.sync1 = source_clocks_i;
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2;
      level_now = s_q.sync2;
      edge_seen = s_q.sync2 & ~s_q.prev;

      // Register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            OFS_DIV_EN: begin
               s_d.regs.div_en = masked(reg_wdata_i, WMASK_DIV_EN);
            end
            OFS_OUT_SRC: begin
               s_d.regs.out_src = masked(reg_wdata_i, WMASK_OUT_SRC);
            end
            OFS_OUT_DIV: begin
               s_d.regs.out_div = masked(reg_wdata_i, WMASK_OUT_DIV);
            end
            OFS_BOOST: begin
               s_d.regs.boost = masked(reg_wdata_i, WMASK_BOOST);
            end
            OFS_SAR: begin
               s_d.regs.sar = masked(reg_wdata_i, WMASK_SAR);
            end
            default: begin
            end
         endcase
      end

      // Register reads; unmapped addresses return zero
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_DIV_EN:  s_d.rdata = s_q.regs.div_en;
            OFS_OUT_SRC: s_d.rdata = s_q.regs.out_src;
            OFS_OUT_DIV: s_d.rdata = s_q.regs.out_div;
            OFS_BOOST:   s_d.rdata = s_q.regs.boost;
            OFS_SAR:     s_d.rdata = s_q.regs.sar;
            default:     s_d.rdata = 8'h00;
         endcase
      end

      // General clock output divider
      new_src = s_q.regs.out_src[2:0];
      new_on  = s_q.regs.out_div[POS_OUT_ON] &&
                (new_src <= SRC_DSP);
      if (s_q.regs.out_div[6:0] == 7'h00) begin
         new_ratio = OUT_RATIO_ZERO;
      end else begin
         new_ratio = {1'b0, s_q.regs.out_div[6:0]};
      end
      if (s_q.outd.src <= SRC_DSP) begin
         out_tick      = edge_seen[s_q.outd.src];
         out_src_level = level_now[s_q.outd.src];
      end else begin
         out_tick      = 1'b0;
         out_src_level = 1'b0;
      end
      if (!s_q.outd.on) begin
         // Idle: pick up new settings right away, output held low
         s_d.outd.cnt   = 7'h00;
         s_d.outd.ratio = new_ratio;
         s_d.outd.src   = new_src;
         s_d.outd.on    = new_on;
      end else if (out_tick) begin
         if ({1'b0, s_q.outd.cnt} == s_q.outd.ratio - 8'h01) begin
            // Period boundary: safe point to change ratio or source
            s_d.outd.cnt   = 7'h00;
            s_d.outd.ratio = new_ratio;
            s_d.outd.src   = new_src;
            s_d.outd.on    = new_on;
         end else begin
            s_d.outd.cnt = s_q.outd.cnt + 7'h01;
         end
      end
      half_ratio = (s_q.outd.ratio + 8'h01) >> 1;
      if (!s_q.outd.on) begin
         s_d.out_clk = 1'b0;
      end else if (s_q.outd.ratio == 8'h01) begin
         // No pass-through pulse on a boundary that stops or moves it
         s_d.out_clk = out_src_level &&
                       !(out_tick && (!new_on || new_src != s_q.outd.src));
      end else begin
         s_d.out_clk = ({1'b0, s_q.outd.cnt} < half_ratio);
      end

      // Boost clock generator
      if (s_q.regs.boost[POS_SRC_AUTO_OFF]) begin
         boost_osc = s_q.regs.boost[POS_SRC_PICK];
      end else begin
         boost_osc = boost_auto_osc_i;
      end
      if (s_q.regs.boost[POS_EN_AUTO_OFF]) begin
         boost_on = s_q.regs.boost[POS_MAN_ON];
      end else begin
         boost_on = boost_auto_on_i;
      end
      // Base 12 MHz halved once for 6 MHz, twice for 3 MHz
      boost_shift = s_q.regs.boost[POS_BOOST_MODE] ? 3'h2 : 3'h1;
      if (s_q.regs.boost[POS_EN_AUTO_OFF]) begin
         boost_shift = boost_shift + {1'b0, s_q.regs.boost[1:0]};
      end
      s_d.boost = gen_step(s_q.boost,
                           boost_osc ? edge_seen[SRC_OSC]
                                     : edge_seen[SRC_PLL],
                           boost_on, boost_shift);

      // SAR clock generator
      if (s_q.regs.sar[POS_SRC_AUTO_OFF]) begin
         sar_osc = s_q.regs.sar[POS_SRC_PICK];
      end else begin
         sar_osc = sar_auto_osc_i;
      end
      if (s_q.regs.sar[POS_EN_AUTO_OFF]) begin
         sar_on = s_q.regs.sar[POS_MAN_ON];
      end else begin
         sar_on = sar_auto_on_i;
      end
      // Mode codes 0..3 map to 6, 3, 1.5 and 12 MHz
      unique case (s_q.regs.sar[7:6])
         2'h0: sar_shift = 3'h1;
         2'h1: sar_shift = 3'h2;
         2'h2: sar_shift = 3'h3;
         2'h3: sar_shift = 3'h0;
      endcase
      if (s_q.regs.sar[POS_EN_AUTO_OFF]) begin
         sar_shift = sar_shift + {1'b0, s_q.regs.sar[1:0]};
      end
      s_d.sar = gen_step(s_q.sar,
                         sar_osc ? edge_seen[SRC_OSC] : edge_seen[SRC_PLL],
                         sar_on, sar_shift);
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_q              <= '0;
         s_q.regs.div_en  <= RST_DIV_EN;
         s_q.regs.out_src <= RST_OUT_SRC;
         s_q.regs.out_div <= RST_OUT_DIV;
         s_q.regs.boost   <= RST_BOOST;
         s_q.regs.sar     <= RST_SAR;
         s_q.outd.ratio   <= 8'h01;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o                     = s_q.rdata;
   assign modulator_divider_on_o          = s_q.regs.div_en[POS_MOD_ON];
   assign primary_bitclk_divider_on_o     = s_q.regs.div_en[POS_PBCLK_ON];
   assign secondary_bitclk_divider_on_o   = s_q.regs.div_en[POS_SBCLK_ON];
   assign primary_framesync_divider_on_o  = s_q.regs.div_en[POS_PFS_ON];
   assign secondary_framesync_divider_on_o = s_q.regs.div_en[POS_SFS_ON];
   assign general_clock_output_o          = s_q.out_clk;
   assign boost_clock_o                   = s_q.boost.level;
   assign sar_clock_o                     = s_q.sar.level;

endmodule : audio_adc_clock_divider_config

`default_nettype wire

/* sim/clk_cfg_props.sv */
`timescale 1ns/10ps
`default_nettype none
module clk_cfg_props
   import clk_cfg_pkg::*;
(
   input wire logic               sys_clk_i,
   input wire logic               reset_i,
   input wire logic [7:0]         reg_addr_i,
   input wire logic               reg_wr_i,
   input wire logic [7:0]         reg_wdata_i,
   input wire logic               reg_rd_i,
   input wire logic [7:0]         reg_rdata_o,
   input wire logic [NUM_SRC-1:0] source_clocks_i,
   input wire logic               boost_auto_osc_i,
   input wire logic               boost_auto_on_i,
   input wire logic               sar_auto_osc_i,
   input wire logic               sar_auto_on_i,
   input wire logic               modulator_divider_on_o,
   input wire logic               primary_bitclk_divider_on_o,
   input wire logic               secondary_bitclk_divider_on_o,
   input wire logic               primary_framesync_divider_on_o,
   input wire logic               secondary_framesync_divider_on_o,
   input wire logic               general_clock_output_o,
   input wire logic               boost_clock_o,
   input wire logic               sar_clock_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic [7:0] src_q, div_q, bst_q, sar_q;
   logic       out_off;
   // Settings take hold at a period boundary, so look one cycle back
   assign out_off = !div_q[POS_OUT_ON] || (src_q[2:0] > SRC_DSP);
   // Shadow of the clock setup registers
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         src_q <= 8'h00;
         div_q <= 8'h01;
         bst_q <= 8'h00;
         sar_q <= 8'h00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == OFS_OUT_SRC) src_q <= reg_wdata_i;
         if (reg_addr_i == OFS_OUT_DIV) div_q <= reg_wdata_i;
         if (reg_addr_i == OFS_BOOST) bst_q <= reg_wdata_i;
         if (reg_addr_i == OFS_SAR) sar_q <= reg_wdata_i;
      end
   end
   sequence s_en_wr;
      reg_wr_i && reg_addr_i == OFS_DIV_EN;
   endsequence
   AST_MOD_ON: assert property (
      s_en_wr |=> modulator_divider_on_o == $past(reg_wdata_i[6]))
      else $error("modulator enable wrong");
   AST_PBCLK_ON: assert property (
      s_en_wr |=> primary_bitclk_divider_on_o == $past(reg_wdata_i[3]))
      else $error("primary bit clock enable wrong");
   AST_SBCLK_ON: assert property (
      s_en_wr |=> secondary_bitclk_divider_on_o == $past(reg_wdata_i[2]))
      else $error("secondary bit clock enable wrong");
   AST_PFS_ON: assert property (
      s_en_wr |=> primary_framesync_divider_on_o == $past(reg_wdata_i[1]))
      else $error("primary frame sync enable wrong");
   AST_SFS_ON: assert property (
      s_en_wr |=> secondary_framesync_divider_on_o == $past(reg_wdata_i[0]))
      else $error("secondary frame sync enable wrong");
   AST_RES_ZERO: assert property (
      reg_rd_i && reg_addr_i == OFS_DIV_EN
      |=> (reg_rdata_o & ~WMASK_DIV_EN) == 8'h00)
      else $error("reserved bits read nonzero");
   AST_UNMAPPED: assert property (
      reg_rd_i && (reg_addr_i < OFS_DIV_EN || reg_addr_i > OFS_SAR)
      |=> reg_rdata_o == 8'h00)
      else $error("unmapped read nonzero");
   AST_OUT_IDLE: assert property (
      $past(out_off) && out_off && !general_clock_output_o
      |=> !general_clock_output_o)
      else $error("disabled output clock rose");
   AST_BST_IDLE: assert property (
      (bst_q[POS_EN_AUTO_OFF] ? !bst_q[POS_MAN_ON] : !boost_auto_on_i)
      && !boost_clock_o |=> !boost_clock_o)
      else $error("disabled boost clock rose");
   AST_SAR_IDLE: assert property (
      (sar_q[POS_EN_AUTO_OFF] ? !sar_q[POS_MAN_ON] : !sar_auto_on_i)
      && !sar_clock_o |=> !sar_clock_o)
      else $error("disabled SAR clock rose");
endmodule : clk_cfg_props
`default_nettype wire

/* sim/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output var  logic [7:0] reg_addr_o,
   output var  logic       reg_wr_o,
   output var  logic [7:0] reg_wdata_o,
   output var  logic       reg_rd_o
);
   initial begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o    = 1'b0;
   end
   // One-edge write strobe, data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= v;
      reg_wr_o    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= ~v;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_o   <= 1'b0;
      #1 v = reg_rdata_i;
   endtask : rd
endmodule : host_model
`default_nettype wire

/* sim/test_audio_adc_clock_divider_config.sv */
`timescale 1ns/10ps
`default_nettype none
module test_audio_adc_clock_divider_config
   import clk_cfg_pkg::*;
   ();
   localparam logic [5:0] BH = 6'h01;
   logic               sys_clk_i, reset_i, bo, bn, so, sn;
   logic [7:0]         rv, d, c;
   logic [NUM_SRC-1:0] src;
   wire logic          reg_wr_i, reg_rd_i;
   wire logic [7:0]    reg_addr_i, reg_wdata_i, reg_rdata_o;
   wire logic [4:0]    ens;
   wire logic [2:0]    outs;
   int                 err_total, n_compared, n, e;
   int                 sar_sh[4] = '{1, 2, 3, 0};
   audio_adc_clock_divider_config #(.BASE_HALF(BH))
      audio_adc_clock_divider_config_inst (
      .sys_clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
      .reg_rdata_o, .source_clocks_i(src), .boost_auto_osc_i(bo),
      .boost_auto_on_i(bn), .sar_auto_osc_i(so), .sar_auto_on_i(sn),
      .modulator_divider_on_o(ens[4]), .primary_bitclk_divider_on_o(ens[3]),
      .secondary_bitclk_divider_on_o(ens[2]),
      .primary_framesync_divider_on_o(ens[1]),
      .secondary_framesync_divider_on_o(ens[0]),
      .general_clock_output_o(outs[0]), .boost_clock_o(outs[1]),
      .sar_clock_o(outs[2]));
   host_model host_model_inst (.sys_clk_i, .reg_rdata_i(reg_rdata_o),
      .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial src = '0;
   always #23.1 src[0] = ~src[0];
   always #31.7 src[1] = ~src[1];
   always #37.3 src[2] = ~src[2];
   always #43.9 src[3] = ~src[3];
   always #29.3 src[4] = ~src[4];
   always #47.1 src[5] = ~src[5];
   task automatic chk8(input logic [7:0] g, input logic [7:0] x);
      n_compared++;
      if (g !== x) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, g, x);
      end
   endtask : chk8
   task automatic chk_span(input int g, input int x);
      n_compared++;
      if (g < x - 1 || g > x + 1) begin
         err_total++;
         $display("mismatch at %0t: span %0d want %0d", $time, g, x);
      end
   endtask : chk_span
   // Source rises over four output periods, after one settling period
   task automatic span(input int o, input int s, output int m);
      int k, r;
      logic p, q;
      k = 0;
      r = 0;
      m = 0;
      p = outs[o];
      q = src[s];
      while (r < 6 && k < 20000) begin
         @(negedge sys_clk_i);
         k++;
         if (r > 1 && src[s] && !q) m++;
         if (outs[o] && !p) r++;
         p = outs[o];
         q = src[s];
      end
      if (r < 6) m = -1;
   endtask : span
   task automatic quiet(input int o, output logic [7:0] cnt);
      logic p;
      cnt = 8'h00;
      repeat (300) @(negedge sys_clk_i);
      p = outs[o];
      repeat (600) begin
         @(negedge sys_clk_i);
         if (outs[o] && !p) cnt++;
         p = outs[o];
      end
   endtask : quiet
   function automatic int per(input int sh);
      return 2 * (int'(BH) << sh);
   endfunction : per
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   initial begin
      #1ms;
      err_total++;
      results();
   end
   initial begin
      reset_i = 1'b1;
      {bo, bn, so, sn} = 4'h5;
      err_total = 0;
      n_compared = 0;
      void'($urandom(32'h7D98));
      repeat (20) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         host_model_inst.rd(8'h44 + 8'(i), rv);
         chk8(rv, (i == 3) ? 8'h01 : 8'h00);
      end
      $display("test reset values done");
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 8'h4F : 8'($urandom) & WMASK_DIV_EN;
         host_model_inst.wr(OFS_DIV_EN, d);
         #1 chk8(8'(ens), 8'({d[6], d[3:0]}));
         host_model_inst.rd(OFS_DIV_EN, rv);
         chk8(rv, d & 8'h4F);
      end
      $display("test divider enables done");
      for (int s = 0; s < NUM_SRC; s++) begin
         d = (s == 2) ? 8'h7F : 8'($urandom_range(9, 2));
         d = (s < 2) ? 8'(s) : d;
         host_model_inst.wr(OFS_OUT_SRC, 8'(s));
         host_model_inst.wr(OFS_OUT_DIV, 8'h80 | d);
         span(0, s, n);
         chk_span(n, 4 * ((d == 0) ? 128 : int'(d)));
      end
      for (int t = 6; t < 8; t++) begin
         host_model_inst.wr(OFS_OUT_SRC, 8'(t));
         host_model_inst.rd(OFS_OUT_SRC, rv);
         chk8(rv, 8'(t));
         quiet(0, c);
         chk8(c, 8'h00);
      end
      host_model_inst.wr(OFS_OUT_SRC, 8'h00);
      host_model_inst.wr(OFS_OUT_DIV, 8'h03);
      quiet(0, c);
      chk8(c, 8'h00);
      chk8(8'(outs[0]), 8'h00);
      $display("test output clock done");
      for (int i = 0; i < 8; i++) begin
         c = 8'($urandom) | 8'h04;
         c[1:0] = 2'(i);
         c[3] = c[3] | (i < 4);
         @(posedge sys_clk_i);
         bo <= 1'($urandom);
         so <= 1'($urandom);
         host_model_inst.wr(OFS_BOOST, {1'b0, 1'(i >> 2), c[5:0]});
         host_model_inst.wr(OFS_SAR, {2'(i >> 1), c[5:0]});
         span(1, ((c[5] ? c[4] : bo) ? 4 : 0), n);
         e = 4 * per((i >> 2) + 1 + (c[3] ? int'(c[1:0]) : 0));
         chk_span(n, e);
         span(2, ((c[5] ? c[4] : so) ? 4 : 0), n);
         e = 4 * per(sar_sh[i >> 1] + (c[3] ? int'(c[1:0]) : 0));
         chk_span(n, e);
      end
      host_model_inst.wr(OFS_BOOST, 8'h08);
      host_model_inst.wr(OFS_SAR, 8'h08);
      quiet(1, c);
      chk8(c, 8'h00);
      quiet(2, c);
      chk8(c, 8'h00);
      host_model_inst.wr(OFS_BOOST, 8'h00);
      host_model_inst.wr(OFS_SAR, 8'h00);
      bn <= 1'b0;
      sn <= 1'b0;
      quiet(1, c);
      chk8(c, 8'h00);
      quiet(2, c);
      chk8(c, 8'h00);
      $display("test boost and SAR clocks done");
      results();
   end
endmodule : test_audio_adc_clock_divider_config
bind audio_adc_clock_divider_config clk_cfg_props clk_cfg_props_inst (.*);
`default_nettype wire
